//--- src/cfp_pkg.sv
/*
  Shared constants for the fetch/execute sequencer: widths, opcode codes,
  phase positions, vectors and field positions.
  Assumes a single 250 MHz core clock and 16-bit program words.
*/
package cfp_pkg;
  localparam int PC_W = 21;
  localparam int WORD_W = 16;
  localparam int STATUS_W = 5;
  localparam int BANK_W = 4;
  localparam int BYTE_W = 8;
  localparam int HIGH_W = 8;
  localparam int UPPER_W = 5;
  localparam int OPER_W = 12;
  localparam int BRA_W = 11;
  localparam int OP_HI = 15;
  localparam int OP_LO = 12;
  localparam int FAST_BIT = 8;
  localparam int PH_N = 4;
  localparam int PH_ONE = 0;
  localparam int PH_TWO = 1;
  localparam int PH_THREE = 2;
  localparam int PH_FOUR = 3;

  localparam logic [PH_N-1:0] PH_RESET = 4'h1;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] TP_STEP = 21'h000001;
  localparam logic [PC_W-1:0] VEC_HIGH_DEF = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW_DEF = 21'h000018;
  localparam logic PC_ALIGN = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'hF000;

  localparam logic [3:0] OP_RET = 4'h0;
  localparam logic [3:0] OP_RETURN_WITH_LITERAL = 4'h1;
  localparam logic [3:0] OP_ADDPCL = 4'h2;
  localparam logic [3:0] OP_MOVLW = 4'h3;
  localparam logic [3:0] OP_MOVLB = 4'h4;
  localparam logic [3:0] OP_LATH = 4'h5;
  localparam logic [3:0] OP_LATU = 4'h6;
  localparam logic [3:0] OP_TBLRD = 4'h7;
  localparam logic [3:0] OP_TABLE_POINTER = 4'h8;
  localparam logic [3:0] OP_STATUS = 4'h9;
  localparam logic [3:0] OP_SKPWZ = 4'hA;
  localparam logic [3:0] OP_BRA = 4'hC;
  localparam logic [3:0] OP_CALL = 4'hD;
  localparam logic [3:0] OP_GOTO = 4'hE;
  localparam logic [3:0] OP_OPERAND = 4'hF;

  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h00;
  localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
  localparam logic [PC_W-1:0] TP_RESET = 21'h000000;
endpackage

//--- src/cfp_ctx_if.sv
/*
  Context carrier between the sequencer and its shadow store.
  Assumes both ends sit on the same core clock.
*/
`timescale 1ns/1ns
interface cfp_ctx_if;
  import cfp_pkg::*;
  logic [BYTE_W-1:0] working;
  logic [STATUS_W-1:0] status;
  logic [BANK_W-1:0] bank;
  logic save;
  logic [BYTE_W-1:0] sh_working;
  logic [STATUS_W-1:0] sh_status;
  logic [BANK_W-1:0] sh_bank;
  logic sh_valid;
  modport core (output working, status, bank, save, input sh_working, sh_status, sh_bank, sh_valid);
  modport store (input working, status, bank, save, output sh_working, sh_status, sh_bank, sh_valid);
endinterface

//--- src/cfp_phase_gen.sv
/*
  Divides the core clock into four one-hot phase enables.
  Assumes synchronous active-low reset.
*/
`timescale 1ns/1ns
module cfp_phase_gen
  import cfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  output logic [PH_N-1:0] phase
);
  // Rotating one-hot keeps the phases non-overlapping
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= PH_RESET;
    end else begin
      phase <= {phase[PH_N-2:0], phase[PH_N-1]};
    end
  end
endmodule

//--- src/cfp_shadow.sv
/*
  One-level shadow of status, working and bank select.
  Has no software port; only the sequencer's save strobe loads it.
*/
`timescale 1ns/1ns
module cfp_shadow (
  input wire logic clk,
  input wire logic rst_n,
  cfp_ctx_if.store ctx
);
  // Data carries no reset: undefined until the first save
  always_ff @(posedge clk) begin
    if (ctx.save) begin
      ctx.sh_working <= ctx.working;
      ctx.sh_status <= ctx.status;
      ctx.sh_bank <= ctx.bank;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctx.sh_valid <= 1'b0;
    end else if (ctx.save) begin
      ctx.sh_valid <= 1'b1;
    end
  end
endmodule

//--- src/cfp_core.sv
/*
  Four-phase fetch/execute sequencer with fast context shadow.
  Assumes program memory returns pm_data for pm_addr within three clocks,
  table data for tbl_addr within two, and an outside return stack.
*/
`timescale 1ns/1ns
module cfp_core
  import cfp_pkg::*;
#(
  parameter logic [PC_W-1:0] VEC_HIGH = VEC_HIGH_DEF,
  parameter logic [PC_W-1:0] VEC_LOW = VEC_LOW_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic [PC_W-1:0] pm_addr,
  input wire logic [WORD_W-1:0] pm_data,
  output logic [PC_W-1:0] tbl_addr,
  input wire logic [BYTE_W-1:0] tbl_data,
  input wire logic irq_req,
  input wire logic irq_high,
  output logic irq_ack,
  output logic ret_push,
  output logic [PC_W-1:0] ret_push_addr,
  output logic ret_pop,
  input wire logic [PC_W-1:0] ret_top,
  output logic [PC_W-1:0] pc,
  output logic [WORD_W-1:0] instruction_holding_reg,
  output logic [BYTE_W-1:0] working_register,
  output logic [STATUS_W-1:0] status,
  output logic [BANK_W-1:0] bank_select_register,
  output logic [HIGH_W-1:0] pc_high_latch,
  output logic [UPPER_W-1:0] pc_upper_latch,
  output logic [PC_W-1:0] table_pointer,
  output logic [BYTE_W-1:0] table_latch,
  output logic [PH_N-1:0] phase,
  output logic shadow_valid
);
  function automatic logic [3:0] op_of(input logic [WORD_W-1:0] w);
    op_of = w[OP_HI:OP_LO];
  endfunction

  function automatic logic is_fast(input logic [WORD_W-1:0] w);
    is_fast = w[FAST_BIT];
  endfunction

  // Two-word target: word address from both words, byte bit forced even
  function automatic logic [PC_W-1:0] abs_target(input logic [WORD_W-1:0] first, input logic [WORD_W-1:0] second);
    abs_target = {second[OPER_W-1:0], first[BYTE_W-1:0], PC_ALIGN};
  endfunction

  cfp_ctx_if ctx ();

  logic phase_one;
  logic phase_two;
  logic phase_four;
  logic [WORD_W-1:0] fetch_word;
  logic fetch_valid;
  logic ir_valid;
  logic dec_live;
  logic [3:0] dec_op;
  logic redirect;
  logic skip;
  logic take_irq;
  logic fast_save;
  logic fast_restore;
  logic save_late;
  logic [PC_W-1:0] next_pc;
  logic [BYTE_W-1:0] pcl_sum;
  logic [PC_W-1:0] bra_off;

  cfp_phase_gen u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .phase(phase)
  );

  cfp_shadow u_shadow (
    .clk(clk),
    .rst_n(rst_n),
    .ctx(ctx)
  );

  assign phase_one = phase[PH_ONE];
  assign phase_two = phase[PH_TWO];
  assign phase_four = phase[PH_FOUR];
  assign ctx.working = working_register;
  assign ctx.status = status;
  assign ctx.bank = bank_select_register;
  assign shadow_valid = ctx.sh_valid;

  // Execute decision, resolved in phase four
  always_comb begin
    redirect = 1'b0;
    skip = 1'b0;
    take_irq = 1'b0;
    fast_save = 1'b0;
    fast_restore = 1'b0;
    next_pc = pc;
    pcl_sum = pm_addr[BYTE_W-1:0] + working_register;
    bra_off = {{(PC_W-BRA_W-1){instruction_holding_reg[BRA_W-1]}},
               instruction_holding_reg[BRA_W-1:0], PC_ALIGN};
    if (dec_live) begin
      case (dec_op)
        OP_GOTO: begin
          redirect = 1'b1;
          next_pc = abs_target(instruction_holding_reg, pm_data);
        end
        OP_CALL: begin
          redirect = 1'b1;
          fast_save = is_fast(instruction_holding_reg);
          next_pc = abs_target(instruction_holding_reg, pm_data);
        end
        OP_BRA: begin
          redirect = 1'b1;
          next_pc = pm_addr + bra_off;
        end
        OP_RET: begin
          redirect = 1'b1;
          fast_restore = is_fast(instruction_holding_reg);
          next_pc = ret_top;
        end
        OP_RETURN_WITH_LITERAL: begin
          redirect = 1'b1;
          next_pc = ret_top;
        end
        OP_ADDPCL: begin
          redirect = 1'b1;
          // Odd offsets are forced even; software owes an even count
          next_pc = {pc_upper_latch, pc_high_latch, pcl_sum[BYTE_W-1:1], PC_ALIGN};
        end
        OP_SKPWZ: begin
          skip = (working_register == BYTE_ZERO);
        end
        default: begin
        end
      endcase
    end
    // Entry only on a non-branching boundary; the word in flight is discarded
    if (irq_req && !redirect && !skip) begin
      take_irq = 1'b1;
      redirect = 1'b1;
      next_pc = irq_high ? VEC_HIGH : VEC_LOW;
    end
  end

  // Copy taken one clock late, so a result written in phase four is included
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      save_late <= 1'b0;
    end else begin
      save_late <= phase_four && (take_irq || fast_save);
    end
  end

  assign ctx.save = save_late;

  // Program counter and fetch address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc <= PC_RESET;
      pm_addr <= PC_RESET;
    end else if (phase_one) begin
      pm_addr <= pc;
      pc <= pc + PC_STEP;
    end else if (phase_four && redirect) begin
      pc <= next_pc;
    end
  end

  // Fetch capture; a branch or skip drops the overlapped word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fetch_word <= WORD_RESET;
      fetch_valid <= 1'b0;
    end else if (phase_four) begin
      fetch_word <= pm_data;
      fetch_valid <= !redirect && !skip;
    end
  end

  // Latch in phase one, decode in phase two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instruction_holding_reg <= WORD_RESET;
      ir_valid <= 1'b0;
      dec_live <= 1'b0;
      dec_op <= OP_OPERAND;
    end else if (phase_one) begin
      instruction_holding_reg <= fetch_word;
      ir_valid <= fetch_valid;
    end else if (phase_two) begin
      dec_live <= ir_valid;
      // A lone operand word decodes to no work at all
      dec_op <= op_of(instruction_holding_reg);
    end else if (phase_four) begin
      dec_live <= 1'b0;
    end
  end

  // Working register, destination written in phase four
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      working_register <= BYTE_ZERO;
    end else if (phase_four && dec_live) begin
      if (fast_restore) begin
        working_register <= ctx.sh_working;
      end else if (dec_op == OP_RETURN_WITH_LITERAL || dec_op == OP_MOVLW) begin
        working_register <= instruction_holding_reg[BYTE_W-1:0];
      end
    end
  end

  // Status and bank move together on a fast return
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= STATUS_RESET;
      bank_select_register <= BANK_RESET;
    end else if (phase_four && dec_live) begin
      if (fast_restore) begin
        status <= ctx.sh_status;
        bank_select_register <= ctx.sh_bank;
      end else if (dec_op == OP_STATUS) begin
        status <= instruction_holding_reg[STATUS_W-1:0];
      end else if (dec_op == OP_MOVLB) begin
        bank_select_register <= instruction_holding_reg[BANK_W-1:0];
      end
    end
  end

  // Latches reach the counter only through a computed jump
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_high_latch <= BYTE_ZERO;
      pc_upper_latch <= STATUS_RESET;
    end else if (phase_four && dec_live) begin
      if (dec_op == OP_LATH) begin
        pc_high_latch <= instruction_holding_reg[HIGH_W-1:0];
      end else if (dec_op == OP_LATU) begin
        pc_upper_latch <= instruction_holding_reg[UPPER_W-1:0];
      end
    end
  end

  // Table read: address out in phase two, byte taken in phase four
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tbl_addr <= TP_RESET;
    end else if (phase_two && ir_valid && op_of(instruction_holding_reg) == OP_TBLRD) begin
      tbl_addr <= table_pointer;
    end
  end

  // Pointer steps by one byte after each read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      table_pointer <= TP_RESET;
      table_latch <= BYTE_ZERO;
    end else if (phase_four && dec_live) begin
      if (dec_op == OP_TBLRD) begin
        table_latch <= tbl_data;
        table_pointer <= table_pointer + TP_STEP;
      end else if (dec_op == OP_TABLE_POINTER) begin
        table_pointer <= {pc_upper_latch, pc_high_latch, instruction_holding_reg[BYTE_W-1:0]};
      end
    end
  end

  // Return stack and interrupt strobes, one clock wide each
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ret_push <= 1'b0;
    end else begin
      ret_push <= phase_four && (take_irq || (dec_live && dec_op == OP_CALL));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ret_pop <= 1'b0;
    end else begin
      ret_pop <= phase_four && dec_live && (dec_op == OP_RET || dec_op == OP_RETURN_WITH_LITERAL);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= phase_four && take_irq;
    end
  end

  // Interrupt returns to the discarded word; a call to the word after its operand
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ret_push_addr <= PC_RESET;
    end else if (phase_four && take_irq) begin
      ret_push_addr <= pm_addr;
    end else if (phase_four && dec_live && dec_op == OP_CALL) begin
      ret_push_addr <= pc;
    end
  end
endmodule

//--- tb/cfp_checker.sv
/*
  Port-level assertions for cfp_core.
  Assumes one core clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module cfp_checker
  import cfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [PH_N-1:0] phase,
  input wire logic [PC_W-1:0] pc,
  input wire logic [PC_W-1:0] pm_addr,
  input wire logic [PC_W-1:0] tbl_addr,
  input wire logic [WORD_W-1:0] instruction_holding_reg,
  input wire logic [BYTE_W-1:0] working_register,
  input wire logic [BYTE_W-1:0] table_latch,
  input wire logic irq_ack,
  input wire logic ret_push,
  input wire logic shadow_valid
);
  logic rst_q;
  // Held one clock so the releasing edge starts no attempt
  always_ff @(posedge clk) begin
    rst_q <= rst_n;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !rst_q);
  sequence s_quad;
    phase == 4'h1 ##1 phase == 4'h2 ##1 phase == 4'h4 ##1 phase == 4'h8;
  endsequence
  a_phase_order: assert property (phase == 4'h1 |-> s_quad)
    else $error("phase order broken");
  a_pc_advance: assert property (phase[PH_ONE] |=> pc == $past(pc) + PC_STEP)
    else $error("pc did not step by two");
  a_fetch_addr: assert property (phase[PH_ONE] |=> pm_addr == $past(pc))
    else $error("fetch address not old pc");
  a_addr_stands: assert property (!phase[PH_ONE] |=> $stable(pm_addr))
    else $error("fetch address moved mid cycle");
  a_pc_quiet: assert property (phase[PH_TWO] || phase[PH_THREE] |=> $stable(pc))
    else $error("pc moved in middle phases");
  a_pc_even: assert property (pc[0] == PC_ALIGN && pm_addr[0] == PC_ALIGN)
    else $error("odd program address");
  a_ir_latch: assert property (!phase[PH_ONE] |=> $stable(instruction_holding_reg))
    else $error("holding register moved off phase one");
  a_dest_write: assert property (!phase[PH_FOUR] |=> $stable(working_register))
    else $error("working register written off phase four");
  a_tbl_byte: assert property (!phase[PH_FOUR] |=> $stable(table_latch))
    else $error("table latch written off phase four");
  a_tbl_addr: assert property (!phase[PH_TWO] |=> $stable(tbl_addr))
    else $error("table address moved off phase two");
  a_ack_save: assert property (irq_ack |-> ret_push ##1 (shadow_valid && !irq_ack))
    else $error("interrupt entry without save");
endmodule

bind cfp_core cfp_checker u_cfp_checker (.clk(clk), .rst_n(rst_n), .phase(phase), .pc(pc),
  .pm_addr(pm_addr), .tbl_addr(tbl_addr), .instruction_holding_reg(instruction_holding_reg),
  .working_register(working_register), .table_latch(table_latch), .irq_ack(irq_ack),
  .ret_push(ret_push), .shadow_valid(shadow_valid));

//--- tb/cfp_pmem.sv
/*
  Program memory and return stack model for cfp_core.
  The bench fills mem directly; fetch and table read are combinational.
*/
`timescale 1ns/1ns
module cfp_pmem
  import cfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [PC_W-1:0] pm_addr,
  output logic [WORD_W-1:0] pm_data,
  input wire logic [PC_W-1:0] tbl_addr,
  output logic [BYTE_W-1:0] tbl_data,
  input wire logic ret_push,
  input wire logic [PC_W-1:0] ret_push_addr,
  input wire logic ret_pop,
  output logic [PC_W-1:0] ret_top
);
  logic [WORD_W-1:0] mem [256];
  logic [PC_W-1:0] stk [32];
  logic [4:0] sp;
  logic [WORD_W-1:0] tw;
  // Word fetch ignores bit 0: low byte sits at the even address
  assign pm_data = mem[pm_addr[8:1]];
  assign tw = mem[tbl_addr[8:1]];
  assign tbl_data = tbl_addr[0] ? tw[15:8] : tw[7:0];
  // Empty stack answers zero, as an underflow would
  assign ret_top = (sp == 5'h00) ? 21'h000000 : stk[sp];
  always @(posedge clk) begin
    if (!rst_n) begin
      sp <= 5'h00;
    end else if (ret_push) begin
      stk[sp + 5'h01] <= ret_push_addr;
      sp <= sp + 5'h01;
    end else if (ret_pop && sp != 5'h00) begin
      sp <= sp - 5'h01;
    end
  end
endmodule

//--- tb/tb.sv
/*
  Self-checking bench: runs a small program twice with random literals.
  Assumes the checker binds itself to cfp_core.
*/
`timescale 1ns/1ns
module tb;
  import cfp_pkg::*;
  `define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_req = 1'b0;
  logic irq_high = 1'b0;
  logic [PC_W-1:0] pm_addr, tbl_addr, ret_push_addr, ret_top, pc, table_pointer;
  logic [WORD_W-1:0] pm_data, instruction_holding_reg, dw;
  logic [BYTE_W-1:0] tbl_data, working_register, table_latch, r1, r3;
  logic [STATUS_W-1:0] status, s;
  logic [BANK_W-1:0] bank_select_register, b;
  logic [PH_N-1:0] phase;
  logic irq_ack, ret_push, ret_pop, shadow_valid;
  int err_count = 0;
  int n_compared = 0;
  initial forever #2 clk = ~clk;
  cfp_core #(.VEC_HIGH(21'h000100), .VEC_LOW(21'h000140)) u_cfp_core (.clk(clk), .rst_n(rst_n),
    .pm_addr(pm_addr), .pm_data(pm_data), .tbl_addr(tbl_addr), .tbl_data(tbl_data),
    .irq_req(irq_req), .irq_high(irq_high), .irq_ack(irq_ack), .ret_push(ret_push),
    .ret_push_addr(ret_push_addr), .ret_pop(ret_pop), .ret_top(ret_top), .pc(pc),
    .instruction_holding_reg(instruction_holding_reg), .working_register(working_register),
    .status(status), .bank_select_register(bank_select_register), .pc_high_latch(),
    .pc_upper_latch(), .table_pointer(table_pointer), .table_latch(table_latch),
    .phase(phase), .shadow_valid(shadow_valid));
  cfp_pmem u_cfp_pmem (.clk(clk), .rst_n(rst_n), .pm_addr(pm_addr), .pm_data(pm_data),
    .tbl_addr(tbl_addr), .tbl_data(tbl_data), .ret_push(ret_push),
    .ret_push_addr(ret_push_addr), .ret_pop(ret_pop), .ret_top(ret_top));
  function automatic logic [7:0] hi(input logic [15:0] w);
    return w[15:8];
  endfunction
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic p(input logic [7:0] a, input logic [15:0] w);
    u_cfp_pmem.mem[a] = w;
  endtask
  task automatic wait_pa(input logic [PC_W-1:0] a);
    int i;
    i = 0;
    while (pm_addr !== a && i < 400) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i >= 400) begin
      err_count++;
      $display("[FAIL] pm_addr exp %0h got %0h", a, pm_addr);
      end_sim();
    end
  endtask
  task automatic raise(input logic h);
    int i;
    i = 0;
    @(posedge clk);
    irq_high <= h;
    irq_req <= 1'b1;
    while (irq_ack !== 1'b1 && i < 100) begin
      @(posedge clk);
      #1;
      i++;
    end
    `CHK("irq_ack", 1'b1, irq_ack)
    if (i >= 100) end_sim();
    @(posedge clk);
    irq_req <= 1'b0;
  endtask
  initial begin
    void'($urandom(32));
    for (int t = 0; t < 2; t++) begin
      {r1, r3, s, b, dw} = 41'($urandom) ^ {9'($urandom), 32'($urandom)};
      @(posedge clk);
      rst_n <= 1'b0;
      for (int i = 0; i < 256; i++) p(8'(i), 16'hF000);
      p(8'h00, {OP_MOVLW, 4'h0, r1});
      p(8'h01, {OP_MOVLB, 8'h00, b});
      p(8'h02, {OP_STATUS, 7'h00, s});
      p(8'h03, 16'hD140);
      p(8'h05, 16'h3004);
      p(8'h06, 16'hD050);
      p(8'h08, 16'h3000);
      p(8'h09, 16'hA000);
      p(8'h0A, 16'hE0AA);
      p(8'h0B, 16'hF0AA);
      p(8'h0C, 16'h305A);
      p(8'h0D, 16'hC001);
      p(8'h0E, 16'h30EE);
      p(8'h0F, 16'h6000);
      p(8'h10, 16'h5000);
      p(8'h11, 16'h8041);
      p(8'h12, 16'h7000);
      p(8'h13, 16'hE060);
      p(8'h20, dw);
      p(8'h40, {OP_MOVLW, 4'h0, ~r1});
      p(8'h41, {OP_MOVLB, 8'h00, ~b});
      p(8'h42, {OP_STATUS, 7'h00, ~s});
      p(8'h43, 16'h0100);
      p(8'h50, 16'h2000);
      p(8'h51, 16'h1011);
      p(8'h52, 16'h1022);
      p(8'h53, {OP_RETURN_WITH_LITERAL, 4'h0, r3});
      p(8'h60, 16'hC7FF);
      p(8'h80, 16'h3077);
      p(8'h81, 16'h0100);
      // Low handler leaves its context to the shadow on purpose
      p(8'hA0, 16'h3033);
      p(8'hA1, 16'hC7FF);
      repeat (10) @(posedge clk);
      #1;
      `CHK("pc", PC_RESET, pc)
      `CHK("ir", WORD_RESET, instruction_holding_reg)
      `CHK("shadow_valid", 1'b0, shadow_valid)
      @(posedge clk);
      rst_n <= 1'b1;
      wait_pa(21'h00000A);
      `CHK("w fast", r1, working_register)
      `CHK("status fast", s, status)
      `CHK("bank fast", b, bank_select_register)
      wait_pa(21'h000010);
      `CHK("w literal", r3, working_register)
      wait_pa(21'h00001E);
      `CHK("w skip", 8'h5A, working_register)
      wait_pa(21'h0000C0);
      `CHK("table_latch", hi(dw), table_latch)
      `CHK("table_pointer", 21'h000042, table_pointer)
      raise(1'b0);
      wait_pa(21'h000142);
      raise(1'b1);
      wait_pa(21'h000102);
      wait_pa(21'h000142);
      `CHK("w nested", 8'h33, working_register)
      $display("test %0d done", t);
    end
    end_sim();
  end
endmodule
